// File: uhc_pkg.sv
package uhc_pkg;

  // Bus geometry
  localparam int unsigned UHC_AW = 12;
  localparam int unsigned UHC_ACK_W = 8;

  // Register indices as printed, byte address is four times the index
  localparam logic [9:0] UHC_IDX_CH0 = 10'h145;
  localparam logic [9:0] UHC_IDX_CHA = 10'h146;
  localparam logic [9:0] UHC_IDX_CFG = 10'h150;
  localparam logic [9:0] UHC_IDX_STAT = 10'h151;
  localparam logic [11:0] UHC_ADDR_CH0 = {UHC_IDX_CH0, 2'b00};
  localparam logic [11:0] UHC_ADDR_CHA = {UHC_IDX_CHA, 2'b00};
  localparam logic [11:0] UHC_ADDR_CFG = {UHC_IDX_CFG, 2'b00};
  localparam logic [11:0] UHC_ADDR_STAT = {UHC_IDX_STAT, 2'b00};

  // Flag bit positions
  localparam int unsigned UHC_BIT_TOTAL = 7;
  localparam int unsigned UHC_BIT_ACK = 6;
  localparam int unsigned UHC_BIT_TERR = 5;
  localparam int unsigned UHC_BIT_COND = 4;
  localparam int unsigned UHC_BIT_DONE = 1;
  localparam int unsigned UHC_BIT_ABORT = 0;
  localparam logic [7:0] UHC_FLAG_MASK = 8'hf3;

  // Config register fields
  localparam int unsigned UHC_CFG_RUN = 0;
  localparam int unsigned UHC_CFG_BO_RUN = 1;
  localparam int unsigned UHC_CFG_CTL_RUN = 2;
  localparam int unsigned UHC_CFG_ACK_LSB = 8;

  // Result codes
  localparam logic [2:0] UHC_RC_OK = 3'h0;
  localparam logic [2:0] UHC_RC_STALL = 3'h1;
  localparam logic [2:0] UHC_RC_OVER = 3'h2;
  localparam logic [2:0] UHC_RC_UNDER = 3'h3;
  localparam logic [2:0] UHC_RC_RETRY = 3'h4;

  // Assist phases and stages, and the retry limit
  localparam logic [1:0] UHC_PH_CMD = 2'h0;
  localparam logic [1:0] UHC_PH_DATA = 2'h1;
  localparam logic [1:0] UHC_PH_STS = 2'h2;
  localparam logic [1:0] UHC_RETRY_LIMIT = 2'h2;

  // Bus responses
  localparam logic [1:0] UHC_RESP_OKAY = 2'h0;
  localparam logic [1:0] UHC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] flags_a;
    logic [1:0] flags_0;
    logic transfer_run;
    logic bulk_only_run;
    logic ctrl_assist_run;
    logic [7:0] ack_target;
    logic [7:0] ack_done;
    logic [2:0] result_code;
    logic [1:0] retry_cnt;
    logic cmd_ok;
    logic data_ok;
    logic bo_stopping;
    logic ctl_stopping;
  } uhc_state_type;

  localparam uhc_state_type UHC_STATE_RST = '0;

endpackage : uhc_pkg

// File: uhc_chan_irq.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE1: Writing one clears a flag, zero keeps
// RULE2: Bit 7 set on whole transfer done
// RULE3: Under bulk assist, needs all three transports
// RULE4: Bit 6 set when ack count reached
// RULE5: Under bulk assist, ack only in data
// RULE6: Bit 5 set on any retry error
// RULE7: Bit 4 on three retries, stall, over/underrun
// RULE8: Bit 4 also when software clears run
// RULE9: Code 000 normal, 001 stall
// RULE10: Code 010 on oversize or excess data
// RULE11: CRC/stuff or bad toggle beat overrun
// RULE12: Code 011 on short packet below total
// RULE13: Code 100 on any retry error
// RULE14: Bit 1 set on status transport done
// RULE15: Bit 1 after stop ending in status
// RULE16: Bit 0 set on bulk transport error
// RULE17: Bit 0 after stop elsewhere or error
// RULE18: Channel 0 abort on assist error
// RULE19: Channel 0 abort after stop misfinish
// RULE20: Channel 0 done when all stages normal
// RULE21: Bits 3 and 2 read zero
module uhc_chan_irq
  import uhc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transaction results, channel A
  input wire logic txn_end,
  input wire logic txn_timeout,
  input wire logic txn_crc_err,
  input wire logic txn_stuff_err,
  input wire logic txn_pid_err,
  input wire logic txn_toggle_err,
  input wire logic txn_stall,
  input wire logic rx_over_max,
  input wire logic rx_over_total,
  input wire logic rx_short,
  input wire logic rx_under_total,
  input wire logic xfer_end,
  // Bulk-only assist
  input wire logic [1:0] bo_phase,
  input wire logic bo_err,
  input wire logic bo_stop_end,
  // Control assist, channel 0
  input wire logic [1:0] ctl_stage,
  input wire logic ctl_err,
  input wire logic ctl_all_ok,
  input wire logic ctl_stop_end,
  // Run controls and result code
  output logic transfer_run,
  output logic bulk_only_run,
  output logic ctrl_assist_run,
  output logic [2:0] result_code
);

  uhc_state_type st_q;
  uhc_state_type st_d;

  logic wr_do;
  logic wr_cha;
  logic wr_ch0;
  logic wr_cfg0;
  logic wr_cfg1;
  logic retry_ev;
  logic stall_ev;
  logic over_ev;
  logic under_ev;
  logic ok_ev;
  logic run_drop;
  logic bo_drop;
  logic ctl_drop;
  logic ack_gate;
  logic ack_hit;
  logic total_ev;
  logic cond_ev;
  logic bo_stop_hit;
  logic ctl_stop_hit;
  logic bo_done_ev;
  logic bo_abort_ev;
  logic ctl_done_ev;
  logic ctl_abort_ev;
  logic [7:0] set_a;
  logic [7:0] clr_a;
  logic [1:0] set_0;
  logic [1:0] clr_0;
  logic [7:0] ack_next;
  logic [31:0] rd_val;
  logic rd_hit;

  // Write decode
  assign wr_do = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
  assign wr_cha = wr_do & (st_q.awaddr == UHC_ADDR_CHA) & st_q.wstrb[0];
  assign wr_ch0 = wr_do & (st_q.awaddr == UHC_ADDR_CH0) & st_q.wstrb[0];
  assign wr_cfg0 = wr_do & (st_q.awaddr == UHC_ADDR_CFG) & st_q.wstrb[0];
  assign wr_cfg1 = wr_do & (st_q.awaddr == UHC_ADDR_CFG) & st_q.wstrb[1];
  assign run_drop = wr_cfg0 & st_q.transfer_run & ~st_q.wdata[UHC_CFG_RUN];
  assign bo_drop = wr_cfg0 & st_q.bulk_only_run & ~st_q.wdata[UHC_CFG_BO_RUN];
  assign ctl_drop = wr_cfg0 & st_q.ctrl_assist_run & ~st_q.wdata[UHC_CFG_CTL_RUN];

  // Result classification, retry first so CRC, stuffing and toggle win
  assign retry_ev = txn_end & (txn_timeout | txn_crc_err | txn_stuff_err
                    | txn_pid_err | txn_toggle_err); // [RULE6] [RULE11] [RULE13]
  assign stall_ev = txn_end & ~retry_ev & txn_stall; // [RULE9]
  assign over_ev = txn_end & ~retry_ev & ~txn_stall
                   & (rx_over_max | rx_over_total); // [RULE10] [RULE11]
  assign under_ev = txn_end & ~retry_ev & ~txn_stall & ~over_ev
                    & rx_short & rx_under_total; // [RULE12]
  assign ok_ev = txn_end & ~retry_ev & ~txn_stall & ~over_ev & ~under_ev;

  // Ack counting, data transport only under bulk assist
  assign ack_gate = ~st_q.bulk_only_run | (bo_phase == UHC_PH_DATA); // [RULE5]
  assign ack_next = st_q.ack_done + 8'h01;
  assign ack_hit = ok_ev & ack_gate & (st_q.ack_target != 8'h00)
                   & (ack_next == st_q.ack_target); // [RULE4]

  // Completion of the whole transfer
  assign total_ev = xfer_end & (~st_q.bulk_only_run
                    | ((bo_phase == UHC_PH_STS) & st_q.cmd_ok & st_q.data_ok)); // [RULE2] [RULE3]

  assign cond_ev = (retry_ev & (st_q.retry_cnt == UHC_RETRY_LIMIT))
                   | stall_ev | over_ev | under_ev // [RULE7]
                   | run_drop; // [RULE8]

  // Bulk-only assist outcomes
  assign bo_stop_hit = bo_stop_end & st_q.bo_stopping;
  assign bo_done_ev = (st_q.bulk_only_run & xfer_end & (bo_phase == UHC_PH_STS)) // [RULE14]
                      | (bo_stop_hit & (bo_phase == UHC_PH_STS) & ~bo_err); // [RULE15]
  assign bo_abort_ev = (st_q.bulk_only_run & bo_err) // [RULE16]
                       | (bo_stop_hit & ((bo_phase != UHC_PH_STS) | bo_err)); // [RULE17]

  // Control assist outcomes
  assign ctl_stop_hit = ctl_stop_end & st_q.ctl_stopping;
  assign ctl_done_ev = (st_q.ctrl_assist_run & ctl_all_ok) // [RULE20]
                       | (ctl_stop_hit & (ctl_stage == UHC_PH_STS) & ~ctl_err);
  assign ctl_abort_ev = (st_q.ctrl_assist_run & ctl_err) // [RULE18]
                        | (ctl_stop_hit & ((ctl_stage != UHC_PH_STS) | ctl_err)); // [RULE19]

  always_comb begin
    set_a = 8'h00;
    set_a[UHC_BIT_TOTAL] = total_ev;
    set_a[UHC_BIT_ACK] = ack_hit;
    set_a[UHC_BIT_TERR] = retry_ev;
    set_a[UHC_BIT_COND] = cond_ev;
    set_a[UHC_BIT_DONE] = bo_done_ev;
    set_a[UHC_BIT_ABORT] = bo_abort_ev;
    set_0 = {ctl_done_ev, ctl_abort_ev};
  end

  // Write one to clear, reserved bits masked off
  assign clr_a = wr_cha ? (st_q.wdata[7:0] & UHC_FLAG_MASK) : 8'h00; // [RULE1] [RULE21]
  assign clr_0 = wr_ch0 ? st_q.wdata[1:0] : 2'h0; // [RULE1]

  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      UHC_ADDR_CHA: rd_val[7:0] = st_q.flags_a; // [RULE21]
      UHC_ADDR_CH0: rd_val[1:0] = st_q.flags_0;
      UHC_ADDR_CFG: begin
        rd_val[UHC_CFG_RUN] = st_q.transfer_run;
        rd_val[UHC_CFG_BO_RUN] = st_q.bulk_only_run;
        rd_val[UHC_CFG_CTL_RUN] = st_q.ctrl_assist_run;
        rd_val[UHC_CFG_ACK_LSB +: UHC_ACK_W] = st_q.ack_target;
      end
      UHC_ADDR_STAT: begin
        rd_val[2:0] = st_q.result_code;
        rd_val[9:8] = st_q.retry_cnt;
        rd_val[23:16] = st_q.ack_done;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    // Write channels
    if (s_axi_awvalid & st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (wr_do) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = ((st_q.awaddr == UHC_ADDR_CHA) | (st_q.awaddr == UHC_ADDR_CH0)
                    | (st_q.awaddr == UHC_ADDR_CFG) | (st_q.awaddr == UHC_ADDR_STAT))
                   ? UHC_RESP_OKAY : UHC_RESP_SLVERR;
    end
    if (st_q.bvalid & s_axi_bready) begin
      st_d.bvalid = 1'b0;
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
    end
    st_d.awready = ~st_d.aw_have;
    st_d.wready = ~st_d.w_have;
    // Read channel
    if (s_axi_arvalid & st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = rd_val;
      st_d.rresp = rd_hit ? UHC_RESP_OKAY : UHC_RESP_SLVERR;
    end else if (st_q.rvalid & s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    st_d.arready = ~st_d.rvalid & ~(s_axi_arvalid & st_q.arready);
    // Config writes
    if (wr_cfg0) begin
      st_d.transfer_run = st_q.wdata[UHC_CFG_RUN];
      st_d.bulk_only_run = st_q.wdata[UHC_CFG_BO_RUN];
      st_d.ctrl_assist_run = st_q.wdata[UHC_CFG_CTL_RUN];
    end
    if (wr_cfg1) begin
      st_d.ack_target = st_q.wdata[UHC_CFG_ACK_LSB +: UHC_ACK_W];
      st_d.ack_done = 8'h00;
    end
    // Stop processing trackers
    if (bo_drop) begin
      st_d.bo_stopping = 1'b1;
    end else if (bo_stop_hit) begin
      st_d.bo_stopping = 1'b0;
    end
    if (ctl_drop) begin
      st_d.ctl_stopping = 1'b1;
    end else if (ctl_stop_hit) begin
      st_d.ctl_stopping = 1'b0;
    end
    // Result code and retry streak
    if (txn_end) begin
      if (retry_ev) begin
        st_d.result_code = UHC_RC_RETRY; // [RULE13]
        st_d.retry_cnt = (st_q.retry_cnt == UHC_RETRY_LIMIT) ? 2'h0 : st_q.retry_cnt + 2'h1;
      end else begin
        st_d.retry_cnt = 2'h0;
        if (stall_ev) begin
          st_d.result_code = UHC_RC_STALL; // [RULE9]
        end else if (over_ev) begin
          st_d.result_code = UHC_RC_OVER; // [RULE10]
        end else if (under_ev) begin
          st_d.result_code = UHC_RC_UNDER; // [RULE12]
        end else begin
          st_d.result_code = UHC_RC_OK; // [RULE9]
        end
      end
    end
    if (ok_ev & ack_gate) begin
      st_d.ack_done = ack_hit ? 8'h00 : ack_next; // [RULE4]
    end
    // Transport progress under bulk assist
    if (xfer_end & st_q.bulk_only_run) begin
      if (bo_phase == UHC_PH_CMD) begin
        st_d.cmd_ok = 1'b1; // [RULE3]
      end else if (bo_phase == UHC_PH_DATA) begin
        st_d.data_ok = 1'b1;
      end else begin
        st_d.cmd_ok = 1'b0;
        st_d.data_ok = 1'b0;
      end
    end
    if (bo_abort_ev) begin
      st_d.cmd_ok = 1'b0;
      st_d.data_ok = 1'b0;
    end
    // Sticky flags, set wins over clear
    st_d.flags_a = ((st_q.flags_a & ~clr_a) | set_a) & UHC_FLAG_MASK; // [RULE1] [RULE21]
    st_d.flags_0 = (st_q.flags_0 & ~clr_0) | set_0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= UHC_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign transfer_run = st_q.transfer_run;
  assign bulk_only_run = st_q.bulk_only_run;
  assign ctrl_assist_run = st_q.ctrl_assist_run;
  assign result_code = st_q.result_code;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_retry_hit;
    retry_ev;
  endsequence

  // Retry streak seen by the checks
  logic [1:0] chk_streak_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_streak_q <= 2'h0;
    end else if (txn_end) begin
      chk_streak_q <= (retry_ev && (chk_streak_q != 2'h2)) ? chk_streak_q + 2'h1 : 2'h0;
    end
  end

  sequence s_third_retry;
    s_retry_hit ##0 (chk_streak_q == 2'h2);
  endsequence

  sequence s_stop_elsewhere;
    bo_stop_end && st_q.bo_stopping && (bo_phase != UHC_PH_STS);
  endsequence

  sequence s_clear_total;
    wr_cha && st_q.wdata[UHC_BIT_TOTAL] && !total_ev;
  endsequence

  w1c_clear_a: assert property (s_clear_total |=> !st_q.flags_a[UHC_BIT_TOTAL]) // [RULE1]
    else $error("flag not cleared by write one");
  total_done_a: assert property (total_ev |=> st_q.flags_a[UHC_BIT_TOTAL]) // [RULE2]
    else $error("transfer total flag missing");
  total_bo_a: assert property ($rose(st_q.flags_a[UHC_BIT_TOTAL]) && $past(st_q.bulk_only_run)
      |-> $past(st_q.cmd_ok) && $past(st_q.data_ok)) // [RULE3]
    else $error("total set before all transports");
  ack_hit_a: assert property (ack_hit |=> st_q.flags_a[UHC_BIT_ACK] && st_q.ack_done == 8'h00) // [RULE4]
    else $error("ack count flag missing");
  ack_phase_a: assert property ($rose(st_q.flags_a[UHC_BIT_ACK]) && $past(st_q.bulk_only_run)
      |-> $past(bo_phase) == UHC_PH_DATA) // [RULE5]
    else $error("ack flag outside data transport");
  txn_error_a: assert property (s_retry_hit |=> st_q.flags_a[UHC_BIT_TERR]
      && st_q.result_code == UHC_RC_RETRY) // [RULE6]
    else $error("retry not reported");
  three_retry_a: assert property (s_third_retry |=> st_q.flags_a[UHC_BIT_COND]) // [RULE7]
    else $error("third retry did not flag condition");
  run_clear_a: assert property (run_drop && !txn_end |=> st_q.flags_a[UHC_BIT_COND]
      && st_q.result_code == $past(st_q.result_code)) // [RULE8]
    else $error("run clear did not flag condition");
  stall_code_a: assert property (stall_ev |=> st_q.result_code == UHC_RC_STALL
      && st_q.flags_a[UHC_BIT_COND]) // [RULE9]
    else $error("stall code wrong");
  over_code_a: assert property (over_ev |=> st_q.result_code == UHC_RC_OVER) // [RULE10]
    else $error("overrun code wrong");
  crc_beats_a: assert property (txn_end && txn_crc_err && rx_over_max
      |=> st_q.result_code == UHC_RC_RETRY) // [RULE11]
    else $error("overrun beat crc error");
  under_code_a: assert property (under_ev |=> st_q.result_code == UHC_RC_UNDER) // [RULE12]
    else $error("underrun code wrong");
  bo_done_a: assert property (bo_done_ev |=> st_q.flags_a[UHC_BIT_DONE]) // [RULE14]
    else $error("bulk done flag missing");
  bo_stop_a: assert property (s_stop_elsewhere |=> st_q.flags_a[UHC_BIT_ABORT]) // [RULE17]
    else $error("stop outside status not aborted");
  bo_abort_a: assert property (st_q.bulk_only_run && bo_err |=> st_q.flags_a[UHC_BIT_ABORT]) // [RULE16]
    else $error("bulk abort flag missing");
  ctl_abort_a: assert property (ctl_abort_ev |=> st_q.flags_0[0]) // [RULE18]
    else $error("control abort flag missing");
  ctl_done_a: assert property (st_q.ctrl_assist_run && ctl_all_ok |=> st_q.flags_0[1]) // [RULE20]
    else $error("control done flag missing");
  rsvd_zero_a: assert property (s_axi_rvalid |-> st_q.flags_a[3:2] == 2'h0) // [RULE21]
    else $error("reserved bits not zero");

endmodule : uhc_chan_irq

`default_nettype wire

// File: uhc_ep_model.sv
`timescale 1ns/10ps
`default_nettype none
module uhc_ep_model
  import uhc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request from bench
  input wire logic go,
  input wire logic [3:0] kind,
  // Outcome of one transaction
  output logic txn_end,
  output logic txn_timeout,
  output logic txn_crc_err,
  output logic txn_stuff_err,
  output logic txn_pid_err,
  output logic txn_toggle_err,
  output logic txn_stall,
  output logic rx_over_max,
  output logic rx_over_total,
  output logic rx_short,
  output logic rx_under_total
);
  logic [10:0] res_q;
  logic [10:0] res_d;
  always_comb begin
    // Idle qualifiers invert every cycle, so each cycle they repeat the value from two cycles before
    res_d = {1'b0, ~res_q[9:0]};
    if (go) begin
      case (kind)
        4'h0: res_d = 11'h400;
        4'h1: res_d = 11'h600;
        4'h2: res_d = 11'h500;
        4'h3: res_d = 11'h480;
        4'h4: res_d = 11'h440;
        4'h5: res_d = 11'h420;
        4'h6: res_d = 11'h410;
        4'h7: res_d = 11'h408;
        4'h8: res_d = 11'h404;
        4'h9: res_d = 11'h403;
        4'ha: res_d = 11'h508;
        4'hb: res_d = 11'h426;
        4'hc: res_d = 11'h503;
        default: res_d = 11'h000;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) res_q <= 11'h000;
    else res_q <= res_d;
  end
  assign {txn_end, txn_timeout, txn_crc_err, txn_stuff_err, txn_pid_err, txn_toggle_err,
          txn_stall, rx_over_max, rx_over_total, rx_short, rx_under_total} = res_q;
endmodule : uhc_ep_model
`default_nettype wire

// File: tb_uhc_chan_irq.sv
`timescale 1ns/10ps
`default_nettype none
module tb_uhc_chan_irq import uhc_pkg::*;;
  logic aclk, aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trun, borun, ctrun;
  logic [1:0] bresp, rresp, bo_phase = 2'h0, ctl_stage = 2'h0;
  logic [2:0] result_code;
  logic go = 1'b0;
  logic [3:0] kind = 4'h0;
  logic [5:0] aux = 6'h00;
  logic tend, tto, tcrc, tstf, tpid, ttog, tstl, omax, otot, rshort, utot;
  int n_fail = 0, num_checks = 0;
  logic [3:0] kinds [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  logic [2:0] codes [12] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4};
  logic [7:0] flg [12] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h10, 8'h10, 8'h20,
                           8'h20, 8'h20};

  uhc_chan_irq uhc_chan_irq_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .txn_end(tend), .txn_timeout(tto), .txn_crc_err(tcrc), .txn_stuff_err(tstf),
    .txn_pid_err(tpid), .txn_toggle_err(ttog), .txn_stall(tstl), .rx_over_max(omax),
    .rx_over_total(otot), .rx_short(rshort), .rx_under_total(utot), .xfer_end(aux[5]),
    .bo_phase(bo_phase), .bo_err(aux[4]), .bo_stop_end(aux[3]), .ctl_stage(ctl_stage),
    .ctl_err(aux[2]), .ctl_all_ok(aux[1]), .ctl_stop_end(aux[0]),
    .transfer_run(trun), .bulk_only_run(borun), .ctrl_assist_run(ctrun),
    .result_code(result_code)
  );

  uhc_ep_model uhc_ep_model_i (
    .aclk(aclk), .aresetn(aresetn), .go(go), .kind(kind),
    .txn_end(tend), .txn_timeout(tto), .txn_crc_err(tcrc), .txn_stuff_err(tstf),
    .txn_pid_err(tpid), .txn_toggle_err(ttog), .txn_stall(tstl), .rx_over_max(omax),
    .rx_over_total(otot), .rx_short(rshort), .rx_under_total(utot)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pend;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      pend = (awvalid && !awready) || (wvalid && !wready);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (pend);
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic wc(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, UHC_RESP_OKAY});
  endtask : wc

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rresp", {30'h0, r}, {30'h0, UHC_RESP_OKAY});
    chk("rdata", d, exp);
  endtask : rdc

  task automatic ev(input logic [3:0] k);
    kind <= k;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : ev

  task automatic apulse(input logic [5:0] v);
    aux <= v;
    @(posedge aclk);
    aux <= 6'h00;
    repeat (3) @(posedge aclk);
  endtask : apulse

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(UHC_ADDR_CHA, 32'h0000_0000);
    rdc(UHC_ADDR_CH0, 32'h0000_0000);
    chk("code", {29'h0, result_code}, 32'h0000_0000);
    // Unmapped place
    wr(12'h7fc, 32'hffff_ffff, r);
    chk("bresp", {30'h0, r}, {30'h0, UHC_RESP_SLVERR});
    rd(12'h7fc, d, r);
    chk("rresp", {30'h0, r}, {30'h0, UHC_RESP_SLVERR});
    chk("rdata", d, 32'h0000_0000);
    // Every outcome kind, streak broken by a clean transaction
    for (int i = 0; i < 12; i++) begin
      ev(kinds[i]);
      chk("code", {29'h0, result_code}, {29'h0, codes[i]});
      rdc(UHC_ADDR_CHA, {24'h0, flg[i]});
      wc(UHC_ADDR_CHA, 32'h0000_00ff);
      rdc(UHC_ADDR_CHA, 32'h0000_0000);
      ev(4'h0);
      chk("code", {29'h0, result_code}, 32'h0000_0000);
    end
    // Write zero and reserved bits, then a retry streak of three
    ev(4'h2);
    wc(UHC_ADDR_CHA, 32'h0000_000c);
    rdc(UHC_ADDR_CHA, 32'h0000_0020);
    ev(4'h3);
    rdc(UHC_ADDR_CHA, 32'h0000_0020);
    ev(4'h5);
    rdc(UHC_ADDR_CHA, 32'h0000_0030);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    ev(4'h0);
    // Run bit cleared by software
    wc(UHC_ADDR_CFG, 32'h0000_0001);
    chk("run", {31'h0, trun}, 32'h0000_0001);
    ev(4'h6);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    wc(UHC_ADDR_CFG, 32'h0000_0000);
    rdc(UHC_ADDR_CHA, 32'h0000_0010);
    chk("code", {29'h0, result_code}, 32'h0000_0001);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    apulse(6'h20);
    rdc(UHC_ADDR_CHA, 32'h0000_0080);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    // Ack count of two
    wc(UHC_ADDR_CFG, 32'h0000_0201);
    ev(4'h0);
    rdc(UHC_ADDR_CHA, 32'h0000_0000);
    ev(4'h0);
    rdc(UHC_ADDR_CHA, 32'h0000_0040);
    // Bulk assist through its three transports
    bo_phase <= UHC_PH_CMD;
    wc(UHC_ADDR_CFG, 32'h0000_0102);
    chk("borun", {31'h0, borun}, 32'h0000_0001);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    ev(4'h0);
    apulse(6'h20);
    rdc(UHC_ADDR_CHA, 32'h0000_0000);
    bo_phase <= UHC_PH_DATA;
    ev(4'h0);
    apulse(6'h20);
    rdc(UHC_ADDR_CHA, 32'h0000_0040);
    bo_phase <= UHC_PH_STS;
    apulse(6'h20);
    rdc(UHC_ADDR_CHA, 32'h0000_00c2);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    apulse(6'h10);
    rdc(UHC_ADDR_CHA, 32'h0000_0001);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    // Bulk stop in status, then elsewhere, then with none pending
    wc(UHC_ADDR_CFG, 32'h0000_0000);
    apulse(6'h08);
    rdc(UHC_ADDR_CHA, 32'h0000_0002);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    wc(UHC_ADDR_CFG, 32'h0000_0002);
    wc(UHC_ADDR_CFG, 32'h0000_0000);
    bo_phase <= UHC_PH_DATA;
    apulse(6'h08);
    rdc(UHC_ADDR_CHA, 32'h0000_0001);
    wc(UHC_ADDR_CHA, 32'h0000_00ff);
    apulse(6'h08);
    rdc(UHC_ADDR_CHA, 32'h0000_0000);
    // Control assist on channel 0, running, then a stop in data stage
    wc(UHC_ADDR_CFG, 32'h0000_0004);
    chk("ctrun", {31'h0, ctrun}, 32'h0000_0001);
    apulse(6'h04);
    rdc(UHC_ADDR_CH0, 32'h0000_0001);
    apulse(6'h02);
    rdc(UHC_ADDR_CH0, 32'h0000_0003);
    wc(UHC_ADDR_CH0, 32'h0000_0001);
    rdc(UHC_ADDR_CH0, 32'h0000_0002);
    wc(UHC_ADDR_CH0, 32'h0000_00ff);
    wc(UHC_ADDR_CFG, 32'h0000_0000);
    ctl_stage <= 2'h1;
    apulse(6'h01);
    rdc(UHC_ADDR_CH0, 32'h0000_0001);
    // Control stop ending in status stage
    wc(UHC_ADDR_CH0, 32'h0000_00ff);
    wc(UHC_ADDR_CFG, 32'h0000_0004);
    wc(UHC_ADDR_CFG, 32'h0000_0000);
    ctl_stage <= 2'h2;
    apulse(6'h01);
    rdc(UHC_ADDR_CH0, 32'h0000_0002);
    final_report();
  end
endmodule : tb_uhc_chan_irq
`default_nettype wire
